// ### hw/accel_regs.sv
// sample config, high-pass, data-ready and orientation register slice
// assumes the serial engine gives one-cycle read/write strobes and that
// the orientation algorithm supplies a candidate state each sample tick
//
// Notes on behaviour
// - ready bit set on overwrite/new flag when enabled
// - ready bit cleared by status then axis read
// - view select picks current or fifo samples
// - per-axis enables raise event on new data
// - cutoff codes halve cutoff, 4 Hz at 400
// - cutoff scales with output data rate
// - filtered delta per axis in own outputs
// - change flag set when any orientation field changes
// - status read clears change flag and interrupt
// - tilt bit shows lockout exceeded, resets zero
// - face code undefined, front or back
// - portrait code undefined, up, down, right, left
// - power-up fields undefined, no lockout
// - previous register mirrors status field layout
// - config holds mode, enable, threshold offset
// - mode zero decrements, one clears debounce
// - detection runs only while enabled
// - threshold is 1g plus 50mg steps
// - rate or mode change restarts debounce
`default_nettype none
module accel_regs #(
  parameter int unsigned DBNC_W = 8
) (
  input  wire logic                         clock_in,
  input  wire logic                         reset_n_in,
  input  wire logic [7:0]                   reg_addr_in,
  input  wire logic                         reg_wr_in,
  input  wire logic                         reg_rd_in,
  input  wire logic [7:0]                   reg_wdata_in,
  output logic      [7:0]                   reg_rdata_out,
  input  wire logic                         sample_tick_in,
  input  wire accel_regs_pkg::sample_t      sample_cur_in,
  input  wire accel_regs_pkg::sample_t      sample_fifo_in,
  input  wire logic [2:0]                   axis_new_in,
  input  wire logic                         sample_overwrite_flag_in,
  input  wire logic                         new_sample_flag_in,
  input  wire logic                         ready_irq_enable_in,
  input  wire logic                         status_read_in,
  input  wire logic                         axis_read_in,
  input  wire accel_regs_pkg::orient_fields_t orient_candidate_in,
  input  wire logic [DBNC_W-1:0]            debounce_count_in,
  input  wire logic [2:0]                   odr_code_in,
  input  wire logic                         active_mode_in,
  output accel_regs_pkg::sample_t           sample_out,
  output accel_regs_pkg::sample_t           delta_out,
  output logic [2:0]                        axis_event_out,
  output logic                              sample_ready_irq_bit_out,
  output logic                              orient_irq_out,
  output logic                              orient_detect_enable_out,
  output logic [10:0]                       lockout_threshold_mg_out
);
  if (DBNC_W < 1 || DBNC_W > 16) begin : g_chk
    $error("accel_regs: DBNC_W out of range");
  end

  localparam int unsigned SW = accel_regs_pkg::SAMPLE_W;
  localparam int unsigned LW = accel_regs_pkg::LP_W;
  localparam int unsigned FW = accel_regs_pkg::HP_FRAC_W;

  // ==========================================================
  // high-pass arithmetic
  // corner tracks the sample rate because the filter steps per sample
  function automatic logic signed [LW-1:0] lp_next(input logic signed [SW-1:0] x,
                                                   input logic signed [LW-1:0] lp,
                                                   input logic [2:0] k);
    logic signed [LW-1:0] xs;
    logic signed [LW-1:0] diff;
    xs = {x[SW-1], x, {FW{1'b0}}};
    diff = xs - lp;
    return lp + (diff >>> k);
  endfunction

  function automatic logic signed [SW-1:0] hp_out(input logic signed [SW-1:0] x,
                                                  input logic signed [LW-1:0] lp);
    logic signed [SW:0] d;
    d = {x[SW-1], x} - lp[LW-1:FW];
    return d[SW-1:0];
  endfunction

  // ==========================================================
  // configuration registers
  logic [7:0] data_cfg_q, data_cfg_d;
  logic [7:0] hp_cut_q, hp_cut_d;
  logic [7:0] orient_cfg_q, orient_cfg_d;
  logic       wr_data_cfg, wr_hp_cut, wr_orient_cfg, rd_stat;

  assign wr_data_cfg   = reg_wr_in && reg_addr_in == accel_regs_pkg::OFF_DATA_CFG;
  assign wr_hp_cut     = reg_wr_in && reg_addr_in == accel_regs_pkg::OFF_HP_CUT;
  assign wr_orient_cfg = reg_wr_in && reg_addr_in == accel_regs_pkg::OFF_ORIENT_CFG;
  assign rd_stat       = reg_rd_in && reg_addr_in == accel_regs_pkg::OFF_ORIENT_STAT;

  always_comb begin
    data_cfg_d   = data_cfg_q;
    hp_cut_d     = hp_cut_q;
    orient_cfg_d = orient_cfg_q;
    // masking keeps unused bits at zero
    if (wr_data_cfg) begin
      data_cfg_d = reg_wdata_in & accel_regs_pkg::DATA_CFG_MASK;
    end
    if (wr_hp_cut) begin
      hp_cut_d = reg_wdata_in & accel_regs_pkg::HP_CUT_MASK;
    end
    if (wr_orient_cfg) begin
      orient_cfg_d = reg_wdata_in & accel_regs_pkg::ORIENT_CFG_MASK;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      data_cfg_q   <= accel_regs_pkg::DATA_CFG_RST;
      hp_cut_q     <= accel_regs_pkg::HP_CUT_RST;
      orient_cfg_q <= accel_regs_pkg::ORIENT_CFG_RST;
    end else begin
      data_cfg_q   <= data_cfg_d;
      hp_cut_q     <= hp_cut_d;
      orient_cfg_q <= orient_cfg_d;
    end
  end

  logic       fifo_view_select;
  logic [1:0] cutoff_code;
  logic [2:0] gravity_trip_offset;
  logic       debounce_mode;
  logic       orient_detect_enable;
  logic [2:0] hp_shift;

  assign fifo_view_select     = data_cfg_q[accel_regs_pkg::BIT_FIFO_VIEW];
  assign cutoff_code          = hp_cut_q[accel_regs_pkg::CUT_LSB +: 2];
  assign gravity_trip_offset  = orient_cfg_q[accel_regs_pkg::GRAVITY_TRIP_OFFSET_LSB +: 3];
  assign debounce_mode        = orient_cfg_q[accel_regs_pkg::BIT_DBNC_MODE];
  assign orient_detect_enable = orient_cfg_q[accel_regs_pkg::BIT_DETECT_EN];
  assign hp_shift             = accel_regs_pkg::HP_SHIFT_BASE + {1'b0, cutoff_code};

  // offset only widens the window here; the sign is the algorithm's concern
  assign lockout_threshold_mg_out = accel_regs_pkg::GRAVITY_MG
    + accel_regs_pkg::GRAVITY_TRIP_OFFSET_STEP_MG * {8'h00, gravity_trip_offset};
  assign orient_detect_enable_out = orient_detect_enable;

  // ==========================================================
  // sample path, filter and events
  accel_regs_pkg::sample_t sample_q, sample_d, delta_q, delta_d;
  logic signed [LW-1:0] lpx_q, lpy_q, lpz_q, lpx_d, lpy_d, lpz_d;
  logic [2:0] event_q, event_d;

  always_comb begin
    sample_d = sample_q;
    delta_d  = delta_q;
    lpx_d    = lpx_q;
    lpy_d    = lpy_q;
    lpz_d    = lpz_q;
    event_d  = axis_new_in & data_cfg_q[2:0];
    if (sample_tick_in) begin
      sample_d  = fifo_view_select ? sample_fifo_in : sample_cur_in;
      lpx_d     = lp_next(sample_cur_in.x, lpx_q, hp_shift);
      lpy_d     = lp_next(sample_cur_in.y, lpy_q, hp_shift);
      lpz_d     = lp_next(sample_cur_in.z, lpz_q, hp_shift);
      delta_d.x = hp_out(sample_cur_in.x, lpx_q);
      delta_d.y = hp_out(sample_cur_in.y, lpy_q);
      delta_d.z = hp_out(sample_cur_in.z, lpz_q);
    end
  end

  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      sample_q <= '0;
      delta_q  <= '0;
      lpx_q    <= '0;
      lpy_q    <= '0;
      lpz_q    <= '0;
      event_q  <= '0;
    end else begin
      sample_q <= sample_d;
      delta_q  <= delta_d;
      lpx_q    <= lpx_d;
      lpy_q    <= lpy_d;
      lpz_q    <= lpz_d;
      event_q  <= event_d;
    end
  end

  assign sample_out     = sample_q;
  assign delta_out      = delta_q;
  assign axis_event_out = event_q;

  // ==========================================================
  // data-ready source bit
  logic ready_q, ready_d, armed_q, armed_d, ready_set;

  assign ready_set = ready_irq_enable_in
    && (sample_overwrite_flag_in || new_sample_flag_in);

  always_comb begin
    ready_d = ready_q;
    armed_d = armed_q;
    if (status_read_in) begin
      armed_d = 1'b1;
    end
    if (armed_q && axis_read_in) begin
      ready_d = 1'b0;
      armed_d = 1'b0;
    end
    // a fresh sample in the clearing cycle is kept
    if (ready_set) begin
      ready_d = 1'b1;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      ready_q <= 1'b0;
      armed_q <= 1'b0;
    end else begin
      ready_q <= ready_d;
      armed_q <= armed_d;
    end
  end

  assign sample_ready_irq_bit_out = ready_q;

  // ==========================================================
  // orientation status
  accel_regs_pkg::orient_fields_t cur_q, cur_d, prev_q, prev_d;
  logic changed_q, changed_d, pending, settled;
  logic [2:0] odr_q;
  logic       active_q, restart;

  assign pending = orient_detect_enable && (orient_candidate_in != cur_q);
  assign restart = (odr_code_in != odr_q) || (active_mode_in != active_q)
    || !orient_detect_enable;

  orient_debounce #(
    .CNT_W (DBNC_W)
  ) u_debounce (
    .clock_in      (clock_in),
    .reset_n_in    (reset_n_in),
    .tick_in       (sample_tick_in),
    .restart_in    (restart),
    .pending_in    (pending),
    .clear_mode_in (debounce_mode),
    .limit_in      (debounce_count_in),
    .settled_out   (settled)
  );

  always_comb begin
    cur_d     = cur_q;
    prev_d    = prev_q;
    changed_d = changed_q;
    if (rd_stat) begin
      prev_d    = cur_q;
      changed_d = 1'b0;
    end
    if (settled) begin
      cur_d     = orient_candidate_in;
      changed_d = 1'b1;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      cur_q     <= accel_regs_pkg::ORIENT_RST;
      prev_q    <= accel_regs_pkg::ORIENT_RST;
      changed_q <= 1'b0;
      odr_q     <= 3'h0;
      active_q  <= 1'b0;
    end else begin
      cur_q     <= cur_d;
      prev_q    <= prev_d;
      changed_q <= changed_d;
      odr_q     <= odr_code_in;
      active_q  <= active_mode_in;
    end
  end

  assign orient_irq_out = changed_q;

  // ==========================================================
  // read data
  logic [7:0] rdata_q, rdata_d;

  always_comb begin
    rdata_d = rdata_q;
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        accel_regs_pkg::OFF_DATA_CFG:    rdata_d = data_cfg_q;
        accel_regs_pkg::OFF_HP_CUT:      rdata_d = hp_cut_q;
        accel_regs_pkg::OFF_ORIENT_STAT: rdata_d = {changed_q, cur_q.z_tilt_exceeded,
                                                    1'b0, cur_q.portrait_side_code,
                                                    cur_q.face_side_code};
        accel_regs_pkg::OFF_ORIENT_PREV: rdata_d = {1'b0, prev_q.z_tilt_exceeded,
                                                    1'b0, prev_q.portrait_side_code,
                                                    prev_q.face_side_code};
        accel_regs_pkg::OFF_ORIENT_CFG:  rdata_d = orient_cfg_q;
        default:                         rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata_out = rdata_q;

  // ==========================================================
  // checks
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!reset_n_in);

  chk_ready_set: assert property (ready_set |=> ready_q)
    else $error("ready bit not set");
  chk_ready_clear: assert property (armed_q && axis_read_in && !ready_set |=> !ready_q)
    else $error("ready bit not cleared");
  chk_ready_hold: assert property ((ready_q && !axis_read_in && !status_read_in) [*2]
    |=> ready_q)
    else $error("ready bit dropped without reads");
  chk_view_mux: assert property (sample_tick_in && fifo_view_select
    |=> sample_q == $past(sample_fifo_in))
    else $error("fifo view not presented");
  chk_axis_event: assert property (axis_new_in[0] && data_cfg_q[0]
    |=> axis_event_out[0])
    else $error("x event missing");
  chk_change_set: assert property (settled |=> changed_q && cur_q == $past(orient_candidate_in))
    else $error("change flag not raised");
  chk_read_clears: assert property (rd_stat && !settled |=> !orient_irq_out)
    else $error("status read did not clear");
  chk_prev_copy: assert property (rd_stat |=> prev_q == $past(cur_q))
    else $error("previous not captured");
  chk_detect_off: assert property (!orient_detect_enable |=> $stable(cur_q))
    else $error("orientation moved while disabled");
  chk_unused_zero: assert property (reg_rd_in && reg_addr_in == accel_regs_pkg::OFF_HP_CUT
    |=> reg_rdata_out[7:2] == 6'h00)
    else $error("unused bits not zero");

  cov_orient_change: cover property (settled ##[1:20] rd_stat);
  cov_ready_cycle: cover property (ready_set ##[1:10] status_read_in ##[1:10] axis_read_in);
  cov_fifo_view: cover property (sample_tick_in && fifo_view_select);
endmodule
`default_nettype wire

// ### common/accel_regs_pkg.sv
// constants, encodings and carriers for the accelerometer register slice
// assumes a single 100 MHz clock and a simple byte-wide register port
`default_nettype none
package accel_regs_pkg;
  // ==========================================================
  // register offsets
  localparam logic [7:0] OFF_DATA_CFG    = 8'h16;
  localparam logic [7:0] OFF_HP_CUT      = 8'h17;
  localparam logic [7:0] OFF_ORIENT_STAT = 8'h18;
  localparam logic [7:0] OFF_ORIENT_PREV = 8'h19;
  localparam logic [7:0] OFF_ORIENT_CFG  = 8'h1a;
  // ==========================================================
  // field positions, masks and reset values
  localparam int unsigned BIT_FIFO_VIEW  = 7;
  localparam int unsigned BIT_CHANGED    = 7;
  localparam int unsigned BIT_DBNC_MODE  = 7;
  localparam int unsigned BIT_DETECT_EN  = 6;
  localparam int unsigned GRAVITY_TRIP_OFFSET_LSB       = 0;
  localparam int unsigned CUT_LSB        = 0;
  localparam logic [7:0] DATA_CFG_MASK   = 8'h87;
  localparam logic [7:0] HP_CUT_MASK     = 8'h03;
  localparam logic [7:0] ORIENT_CFG_MASK = 8'hc7;
  localparam logic [7:0] DATA_CFG_RST    = 8'h00;
  localparam logic [7:0] HP_CUT_RST      = 8'h00;
  localparam logic [7:0] ORIENT_CFG_RST  = 8'h83;
  // ==========================================================
  // filter and lockout arithmetic
  localparam int unsigned SAMPLE_W      = 12;
  localparam int unsigned HP_FRAC_W     = 8;
  localparam int unsigned LP_W          = SAMPLE_W + HP_FRAC_W + 1;
  localparam logic [2:0]  HP_SHIFT_BASE = 3'h4;
  localparam logic [10:0] GRAVITY_MG    = 11'h3e8;
  localparam logic [10:0] GRAVITY_TRIP_OFFSET_STEP_MG  = 11'h032;
  // ==========================================================
  // orientation encodings
  typedef enum logic [1:0] {
    FACE_UNDEF = 2'h0,
    FACE_FRONT = 2'h1,
    FACE_BACK  = 2'h2
  } face_side_t;
  typedef enum logic [2:0] {
    PORT_UNDEF   = 3'h0,
    PORT_UP      = 3'h1,
    PORT_DOWN    = 3'h2,
    LAND_RIGHT   = 3'h3,
    LAND_LEFT    = 3'h4
  } portrait_side_t;
  typedef struct packed {
    logic           z_tilt_exceeded;
    portrait_side_t portrait_side_code;
    face_side_t     face_side_code;
  } orient_fields_t;
  localparam orient_fields_t ORIENT_RST = '{1'b0, PORT_UNDEF, FACE_UNDEF};
  typedef struct packed {
    logic signed [SAMPLE_W-1:0] x;
    logic signed [SAMPLE_W-1:0] y;
    logic signed [SAMPLE_W-1:0] z;
  } sample_t;
endpackage
`default_nettype wire

// ### hw/orient_debounce.sv
// orientation debounce counter, one step per sample tick
// assumes tick_in is a one-cycle enable at the output data rate
`default_nettype none
module orient_debounce #(
  parameter int unsigned CNT_W = 8
) (
  input  wire logic             clock_in,
  input  wire logic             reset_n_in,
  input  wire logic             tick_in,
  input  wire logic             restart_in,
  input  wire logic             pending_in,
  input  wire logic             clear_mode_in,
  input  wire logic [CNT_W-1:0] limit_in,
  output logic                  settled_out
);
  if (CNT_W < 1 || CNT_W > 16) begin : g_chk
    $error("orient_debounce: CNT_W out of range");
  end

  logic [CNT_W-1:0] count_q;
  logic [CNT_W-1:0] count_d;

  // ==========================================================
  // counter
  always_comb begin
    count_d = count_q;
    if (restart_in) begin
      count_d = '0;
    end else if (tick_in) begin
      if (pending_in) begin
        if (count_q < limit_in) begin
          count_d = count_q + 1'b1;
        end
      end else if (clear_mode_in) begin
        count_d = '0;
      end else if (count_q != '0) begin
        count_d = count_q - 1'b1;
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end

  assign settled_out = tick_in && pending_in && !restart_in && (count_q >= limit_in);

  // ==========================================================
  // checks
  chk_restart_zero: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    restart_in |=> count_q == '0) else $error("debounce not restarted");
  chk_clear_mode: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    tick_in && !pending_in && clear_mode_in && !restart_in |=> count_q == '0)
    else $error("debounce not cleared in clear mode");
endmodule
`default_nettype wire

// ### sim/host_model.sv
// host side of the register port: byte reads and writes, status/axis read pulses
// assumes one-cycle strobes taken on the rising edge, read data valid the cycle after
`default_nettype none
module host_model (
  input  wire logic       clock_in,
  input  wire logic [7:0] reg_rdata_in,
  output logic      [7:0] reg_addr_out,
  output logic            reg_wr_out,
  output logic            reg_rd_out,
  output logic      [7:0] reg_wdata_out,
  output logic            status_read_out,
  output logic            axis_read_out
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    reg_addr_out = 8'h00;
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
    reg_wdata_out = 8'h00;
    status_read_out = 1'b0;
    axis_read_out = 1'b0;
  end
  // ==========================================================
  // register cycles
  // address and data are scrambled once released so stale values never look valid
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_in);
    #1;
    reg_addr_out = a;
    reg_wdata_out = d;
    reg_wr_out = 1'b1;
    @(posedge clock_in);
    #1;
    reg_wr_out = 1'b0;
    reg_addr_out = ~a;
    reg_wdata_out = ~d;
  endtask
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock_in);
    #1;
    reg_addr_out = a;
    reg_rd_out = 1'b1;
    @(posedge clock_in);
    #1;
    reg_rd_out = 1'b0;
    reg_addr_out = ~a;
    d = reg_rdata_in;
  endtask
  // ==========================================================
  // general status and axis sample reads
  task automatic pulse_read(input logic status, input logic axis);
    @(posedge clock_in);
    #1;
    status_read_out = status;
    axis_read_out = axis;
    @(posedge clock_in);
    #1;
    status_read_out = 1'b0;
    axis_read_out = 1'b0;
  endtask
  task automatic read_status_then_axis();
    pulse_read(1'b1, 1'b0);
    pulse_read(1'b0, 1'b1);
  endtask
endmodule
`default_nettype wire

// ### sim/accel_regs_tb.sv
// self-checking bench for the accelerometer register slice
// assumes the host model drives the register port and read pulses
`default_nettype none
module accel_regs_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
  logic reg_wr, reg_rd, status_read, axis_read;
  logic sample_tick_in = 1'b0;
  accel_regs_pkg::sample_t sample_cur_in = '0;
  accel_regs_pkg::sample_t sample_fifo_in = '0;
  accel_regs_pkg::sample_t sample_out, delta_out;
  logic [2:0] axis_new_in = 3'h0;
  logic overwrite_in = 1'b0;
  logic new_flag_in = 1'b0;
  logic ready_en_in = 1'b0;
  accel_regs_pkg::orient_fields_t cand_in = '0;
  logic [7:0] dbnc_in = 8'h00;
  logic [2:0] odr_in = 3'h0;
  logic active_in = 1'b1;
  logic [2:0] axis_event;
  logic ready_bit, orient_irq, detect_en;
  logic [10:0] thresh_mg;
  int failures = 0;
  int n_tests = 0;
  always #5 clock_in = ~clock_in;
  host_model u_host (.clock_in(clock_in), .reg_rdata_in(reg_rdata), .reg_addr_out(reg_addr),
    .reg_wr_out(reg_wr), .reg_rd_out(reg_rd), .reg_wdata_out(reg_wdata),
    .status_read_out(status_read), .axis_read_out(axis_read));
  accel_regs #(.DBNC_W(8)) u_dut (.clock_in(clock_in), .reset_n_in(reset_n_in),
    .reg_addr_in(reg_addr), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
    .reg_wdata_in(reg_wdata), .reg_rdata_out(reg_rdata), .sample_tick_in(sample_tick_in),
    .sample_cur_in(sample_cur_in), .sample_fifo_in(sample_fifo_in), .axis_new_in(axis_new_in),
    .sample_overwrite_flag_in(overwrite_in), .new_sample_flag_in(new_flag_in),
    .ready_irq_enable_in(ready_en_in), .status_read_in(status_read), .axis_read_in(axis_read),
    .orient_candidate_in(cand_in), .debounce_count_in(dbnc_in), .odr_code_in(odr_in),
    .active_mode_in(active_in), .sample_out(sample_out), .delta_out(delta_out),
    .axis_event_out(axis_event), .sample_ready_irq_bit_out(ready_bit),
    .orient_irq_out(orient_irq), .orient_detect_enable_out(detect_en),
    .lockout_threshold_mg_out(thresh_mg));
  // ==========================================================
  // helpers
  task automatic check(input string what, input logic [35:0] exp, input logic [35:0] got);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    u_host.read_reg(a, d);
    check($sformatf("reg %h", a), {28'h0, exp}, {28'h0, d});
  endtask
  task automatic tick();
    @(posedge clock_in);
    #1;
    sample_tick_in = 1'b1;
    @(posedge clock_in);
    #1;
    sample_tick_in = 1'b0;
  endtask
  task automatic pulse_flags(input logic ow, input logic nw);
    @(posedge clock_in);
    #1;
    overwrite_in = ow;
    new_flag_in = nw;
    @(posedge clock_in);
    #1;
    overwrite_in = 1'b0;
    new_flag_in = 1'b0;
    @(posedge clock_in);
    #1;
  endtask
  // ==========================================================
  // scenarios
  task automatic test_reset();
    rd(8'h16, 8'h00);
    rd(8'h17, 8'h00);
    rd(8'h18, 8'h00);
    rd(8'h19, 8'h00);
    rd(8'h1a, 8'h83);
    rd(8'h55, 8'h00);
    check("threshold", 36'd1150, {25'h0, thresh_mg});
    check("detect_en", 36'h0, {35'h0, detect_en});
    $display("test reset done");
  endtask
  task automatic test_masks();
    for (int k = 0; k < 4; k++) begin
      u_host.write_reg(8'h17, 8'hfc | 8'(k));
      rd(8'h17, 8'(k));
    end
    u_host.write_reg(8'h16, 8'hff);
    rd(8'h16, 8'h87);
    u_host.write_reg(8'h1a, 8'hff);
    rd(8'h1a, 8'hc7);
    check("threshold", 36'd1350, {25'h0, thresh_mg});
    u_host.write_reg(8'h1a, 8'h80);
    check("threshold", 36'd1000, {25'h0, thresh_mg});
    u_host.write_reg(8'h18, 8'hff);
    u_host.write_reg(8'h19, 8'hff);
    rd(8'h18, 8'h00);
    rd(8'h19, 8'h00);
    u_host.write_reg(8'h16, 8'h00);
    $display("test masks done");
  endtask
  task automatic test_ready();
    pulse_flags(1'b1, 1'b1);
    check("ready off", 36'h0, {35'h0, ready_bit});
    ready_en_in = 1'b1;
    pulse_flags(1'b0, 1'b1);
    check("ready new", 36'h1, {35'h0, ready_bit});
    u_host.pulse_read(1'b0, 1'b1);
    check("axis only", 36'h1, {35'h0, ready_bit});
    u_host.read_status_then_axis();
    check("cleared", 36'h0, {35'h0, ready_bit});
    pulse_flags(1'b1, 1'b0);
    check("ready ovw", 36'h1, {35'h0, ready_bit});
    u_host.read_status_then_axis();
    check("cleared", 36'h0, {35'h0, ready_bit});
    $display("test ready done");
  endtask
  task automatic test_events_view();
    u_host.write_reg(8'h16, 8'h05);
    @(posedge clock_in);
    #1;
    axis_new_in = 3'h7;
    @(posedge clock_in);
    #1;
    axis_new_in = 3'h0;
    check("events", 36'h5, {33'h0, axis_event});
    @(posedge clock_in);
    #1;
    check("events end", 36'h0, {33'h0, axis_event});
    sample_cur_in = accel_regs_pkg::sample_t'(36'h123456789);
    sample_fifo_in = accel_regs_pkg::sample_t'(36'h9abcdef01);
    tick();
    check("current", 36'h123456789, sample_out);
    check("delta first", 36'h123456789, delta_out);
    u_host.write_reg(8'h16, 8'h80);
    tick();
    check("fifo", 36'h9abcdef01, sample_out);
    // code 3 left by the mask test: lowpass takes 1/128 of each step
    check("delta code3", 36'h12144e77a, delta_out);
    $display("test events view done");
  endtask
  task automatic test_orient();
    u_host.write_reg(8'h1a, 8'h83);
    cand_in = accel_regs_pkg::orient_fields_t'(6'h05);
    tick();
    check("irq off", 36'h0, {35'h0, orient_irq});
    rd(8'h18, 8'h00);
    u_host.write_reg(8'h1a, 8'hc3);
    check("detect_en", 36'h1, {35'h0, detect_en});
    tick();
    check("irq", 36'h1, {35'h0, orient_irq});
    rd(8'h18, 8'h85);
    check("irq clr", 36'h0, {35'h0, orient_irq});
    rd(8'h19, 8'h05);
    cand_in = accel_regs_pkg::orient_fields_t'(6'h25);
    tick();
    rd(8'h18, 8'hc5);
    rd(8'h19, 8'h45);
    dbnc_in = 8'h01;
    cand_in = accel_regs_pkg::orient_fields_t'(6'h12);
    tick();
    cand_in = accel_regs_pkg::orient_fields_t'(6'h25);
    tick();
    cand_in = accel_regs_pkg::orient_fields_t'(6'h12);
    tick();
    check("cleared cnt", 36'h0, {35'h0, orient_irq});
    odr_in = 3'h1;
    tick();
    check("rate restart", 36'h0, {35'h0, orient_irq});
    tick();
    check("settled", 36'h1, {35'h0, orient_irq});
    rd(8'h18, 8'h92);
    // decrement mode, limit 2; standby entry must drop the leftover count
    u_host.write_reg(8'h1a, 8'h43);
    dbnc_in = 8'h02;
    active_in = 1'b0;
    cand_in = accel_regs_pkg::orient_fields_t'(6'h25);
    tick();
    tick();
    cand_in = accel_regs_pkg::orient_fields_t'(6'h12);
    tick();
    cand_in = accel_regs_pkg::orient_fields_t'(6'h25);
    tick();
    check("decrement", 36'h0, {35'h0, orient_irq});
    tick();
    check("dec settled", 36'h1, {35'h0, orient_irq});
    rd(8'h18, 8'hc5);
    $display("test orient done");
  endtask
  // ==========================================================
  // run control
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    #50000;
    failures++;
    print_verdict();
  end
  initial begin
    repeat (4) @(posedge clock_in);
    #1;
    reset_n_in = 1'b1;
    test_reset();
    test_masks();
    test_ready();
    test_events_view();
    test_orient();
    print_verdict();
  end
endmodule
`default_nettype wire
